// ### inc/rx_alarm_pkg.sv
/*
  Shared constants and types of the receive alarm monitor.
  Assumes a 25 MHz system clock; register offsets are byte addresses
  of an 8-bit register port.
*/
package rx_alarm_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_PRIMARY_CONTROL = 8'h01;
  localparam logic [7:0] OFS_ALARM1_INT_STATUS = 8'h04;
  localparam logic [7:0] OFS_ALARM2_INT_STATUS = 8'h05;
  localparam logic [7:0] OFS_ALARM1_INT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_RECEIVER_CONFIGURATION = 8'h40;
  localparam logic [7:0] OFS_RX_ALARM_SIGNAL_CONFIG = 8'h45;
  localparam logic [7:0] OFS_ALARM_ERROR_LATCH_CONFIG = 8'h46;
  localparam logic [7:0] OFS_ALARM1_STATUS = 8'h47;
  localparam logic [7:0] OFS_ALARM3_STATUS = 8'h49;
  localparam logic [7:0] OFS_ALARM_EVENT_COUNTER = 8'h5A;
  localparam logic [7:0] OFS_TX_ALARM_CONFIG = 8'h75;

  // ----------------------------------------
  // Field positions and reset value
  // ----------------------------------------
  localparam int BIT_LINE_RATE_SELECT = 0;
  localparam int BIT_FRAME_LOSS_INTEG = 0;
  localparam int BIT_ANALOG_SOURCE = 1;
  localparam int BIT_ALARM_HOLD = 0;
  localparam int BIT_AUTO_TX_ALARM = 0;
  localparam int BIT_COUNTER_OVERFLOW = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int INTEG_TIME_MS = 2000;
  localparam int INTEG_CYCLES = INTEG_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam int ANALOG_TIME_US = 1000;
  localparam int ANALOG_CYCLES = ANALOG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CLK_LOSS_TIME_NS = 4000;
  localparam int CLK_LOSS_CYCLES = CLK_LOSS_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Line criteria
  // ----------------------------------------
  localparam logic [6:0] LOS_RUN_T1 = 7'd100;
  localparam logic [6:0] LOS_RUN_E1 = 7'd32;
  localparam logic [7:0] LOS_WINDOW_BITS = 8'd175;
  localparam logic [7:0] LOS_MIN_ONES = 8'd22;
  localparam logic [12:0] AIS_WIN_T1 = 13'd4632;
  localparam logic [12:0] AIS_MAX_ZERO_T1 = 13'd4;
  localparam logic [12:0] AIS_WIN_E1 = 13'd512;
  localparam logic [12:0] AIS_MAX_ZERO_E1 = 13'd2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic remoteAlarm;
    logic rxAlarmInd;
    logic analogLoss;
    logic signalLoss;
    logic frameLoss;
  } alarm_s;

  typedef enum logic [1:0] {
    LOS_IDLE = 2'b00,
    LOS_HUNT = 2'b01,
    LOS_WINDOW = 2'b11
  } los_state_e;

endpackage

// ### hdl/rx_line_alarm_monitor.sv
/*
  Receive alarm monitor of one framer: frame loss, signal loss,
  analog loss, alarm indication and remote alarm, behind an 8-bit
  register port.
  Assumes the line clock and data arrive from outside the clock
  domain, and that framer inputs and the one-second tick are on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_line_alarm_monitor
  import rx_alarm_pkg::*;
#(
  parameter int INTEG_LEN = INTEG_CYCLES,
  parameter int ANALOG_LEN = ANALOG_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Line interface
  input wire logic rxLineClockIn,
  input wire logic rxLineData,
  // Framer and timer
  input wire logic basicFrameAlignLoss,
  input wire logic crcMultiframeAlignLoss,
  input wire logic signalingMultiframeAlignLoss,
  input wire logic [1:0] frameLossReason,
  input wire logic remoteAlarmIndication,
  input wire logic oneSecondTick,
  // Outputs
  output logic [7:0] frameCriteria,
  output logic txAlarmRequest,
  output logic alarmIrq
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] primaryCtrl_r;
  logic [7:0] rxConfig_r;
  logic [7:0] signalCfg_r;
  logic [7:0] latchCfg_r;
  logic [7:0] txCfg_r;
  logic [4:0] alarm1Ena_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      primaryCtrl_r <= REG_RESET;
      rxConfig_r <= REG_RESET;
      signalCfg_r <= REG_RESET;
      latchCfg_r <= REG_RESET;
      txCfg_r <= REG_RESET;
      alarm1Ena_r <= REG_RESET[4:0];
    end
    else if (regWr)
    begin
      case (regAddr)
        OFS_PRIMARY_CONTROL: primaryCtrl_r <= regWrData;
        OFS_RECEIVER_CONFIGURATION: rxConfig_r <= regWrData;
        OFS_RX_ALARM_SIGNAL_CONFIG: signalCfg_r <= regWrData;
        OFS_ALARM_ERROR_LATCH_CONFIG: latchCfg_r <= regWrData;
        OFS_TX_ALARM_CONFIG: txCfg_r <= regWrData;
        OFS_ALARM1_INT_ENABLE: alarm1Ena_r <= regWrData[4:0];
        default: ;
      endcase
    end
  end

  logic isT1;
  logic holdOn;
  logic integOn;
  assign isT1 = primaryCtrl_r[BIT_LINE_RATE_SELECT];
  assign holdOn = latchCfg_r[BIT_ALARM_HOLD];
  assign integOn = isT1 & signalCfg_r[BIT_FRAME_LOSS_INTEG];
  // The offline framer applies the chosen loss criteria
  assign frameCriteria = rxConfig_r;

  // ----------------------------------------
  // Line synchroniser
  // ----------------------------------------
  logic clkMeta_r;
  logic clkSync_r;
  logic clkLast_r;
  logic dataMeta_r;
  logic dataSync_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clkMeta_r <= 1'b0;
      clkSync_r <= 1'b0;
      clkLast_r <= 1'b0;
      dataMeta_r <= 1'b0;
      dataSync_r <= 1'b0;
    end
    else
    begin
      clkMeta_r <= rxLineClockIn;
      clkSync_r <= clkMeta_r;
      clkLast_r <= clkSync_r;
      dataMeta_r <= rxLineData;
      dataSync_r <= dataMeta_r;
    end
  end

  logic bitStb;
  assign bitStb = clkSync_r & ~clkLast_r;

  // ----------------------------------------
  // Line clock watchdog
  // ----------------------------------------
  // A stopped line clock cannot clock its own detector
  logic [7:0] clkGap_r;
  logic clockAbsent;
  assign clockAbsent = (clkGap_r == 8'(CLK_LOSS_CYCLES));

  always_ff @(posedge clk)
  begin
    if (reset)
      clkGap_r <= 8'h00;
    else if (clkSync_r != clkLast_r)
      clkGap_r <= 8'h00;
    else if (!clockAbsent)
      clkGap_r <= clkGap_r + 8'h01;
  end

  // ----------------------------------------
  // Signal loss
  // ----------------------------------------
  logic [6:0] zeroRun_r;
  logic [6:0] runLimit;
  logic losRun;
  assign runLimit = isT1 ? LOS_RUN_T1 : LOS_RUN_E1;
  assign losRun = (zeroRun_r >= runLimit);

  always_ff @(posedge clk)
  begin
    if (reset)
      zeroRun_r <= 7'h00;
    else if (bitStb)
    begin
      if (dataSync_r)
        zeroRun_r <= 7'h00;
      else if (zeroRun_r != 7'h7F)
        zeroRun_r <= zeroRun_r + 7'h01;
    end
  end

  los_state_e losState_r;
  logic sigLoss_r;
  logic [7:0] winBits_r;
  logic [7:0] winOnes_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      losState_r <= LOS_IDLE;
      sigLoss_r <= 1'b0;
      winBits_r <= 8'h00;
      winOnes_r <= 8'h00;
    end
    else
    begin
      case (losState_r)
        LOS_IDLE:
        begin
          if (losRun)
          begin
            sigLoss_r <= 1'b1;
            losState_r <= LOS_HUNT;
          end
        end
        LOS_HUNT:
        begin
          if (bitStb && dataSync_r)
          begin
            winBits_r <= 8'h01;
            winOnes_r <= 8'h01;
            losState_r <= LOS_WINDOW;
          end
        end
        LOS_WINDOW:
        begin
          if (losRun)
            losState_r <= LOS_HUNT;
          else if (bitStb)
          begin
            winBits_r <= winBits_r + 8'h01;
            winOnes_r <= winOnes_r + {7'h00, dataSync_r};
            if (winBits_r == LOS_WINDOW_BITS - 8'h01)
            begin
              // Density judged over the full window
              if (winOnes_r + {7'h00, dataSync_r} >= LOS_MIN_ONES)
              begin
                sigLoss_r <= 1'b0;
                losState_r <= LOS_IDLE;
              end
              else
                losState_r <= LOS_HUNT;
            end
          end
        end
        default: losState_r <= LOS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      txAlarmRequest <= 1'b0;
    else
      txAlarmRequest <= txCfg_r[BIT_AUTO_TX_ALARM] & sigLoss_r;
  end

  // ----------------------------------------
  // Analog loss
  // ----------------------------------------
  logic [31:0] losTime_r;

  always_ff @(posedge clk)
  begin
    if (reset || !sigLoss_r)
      losTime_r <= 32'h0;
    else if (losTime_r != 32'(ANALOG_LEN))
      losTime_r <= losTime_r + 32'h1;
  end

  // ----------------------------------------
  // Frame loss
  // ----------------------------------------
  logic rawLoss;
  logic integLoss_r;
  logic [31:0] integCnt_r;
  assign rawLoss = isT1 ? basicFrameAlignLoss
    : (basicFrameAlignLoss | crcMultiframeAlignLoss
    | signalingMultiframeAlignLoss);

  // Integrated state follows the raw state after it stands two seconds
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      integLoss_r <= 1'b0;
      integCnt_r <= 32'h0;
    end
    else if (!integOn || rawLoss == integLoss_r)
      integCnt_r <= 32'h0;
    else if (integCnt_r == 32'(INTEG_LEN - 1))
    begin
      integLoss_r <= rawLoss;
      integCnt_r <= 32'h0;
    end
    else
      integCnt_r <= integCnt_r + 32'h1;
  end

  alarm_s cur;
  always_comb
  begin
    cur.frameLoss = integOn ? integLoss_r : rawLoss;
    cur.signalLoss = sigLoss_r;
    cur.analogLoss = signalCfg_r[BIT_ANALOG_SOURCE] ? clockAbsent
      : (losTime_r == 32'(ANALOG_LEN));
    cur.rxAlarmInd = 1'b0;
    cur.remoteAlarm = remoteAlarmIndication;
  end

  logic lossLast_r;
  logic [1:0] reason_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lossLast_r <= 1'b0;
      reason_r <= 2'b00;
    end
    else
    begin
      lossLast_r <= cur.frameLoss;
      if (cur.frameLoss && !lossLast_r)
        reason_r <= frameLossReason;
    end
  end

  // ----------------------------------------
  // Alignment loss counter
  // ----------------------------------------
  logic fredLast_r;
  logic fredRise;
  logic cntRead;
  logic [3:0] lossCnt_r;
  logic cntOvf_r;
  assign fredRise = basicFrameAlignLoss & ~fredLast_r;
  assign cntRead = regRd && (regAddr == OFS_ALARM_EVENT_COUNTER);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fredLast_r <= 1'b0;
      lossCnt_r <= 4'h0;
    end
    else
    begin
      fredLast_r <= basicFrameAlignLoss;
      if (fredRise)
        lossCnt_r <= (cntRead ? 4'h0 : lossCnt_r) + 4'h1;
      else if (cntRead)
        lossCnt_r <= 4'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cntOvf_r <= 1'b0;
    else if (fredRise && lossCnt_r == 4'hF && !cntRead)
      cntOvf_r <= 1'b1;
    else if (regRd && regAddr == OFS_ALARM2_INT_STATUS)
      cntOvf_r <= 1'b0;
  end

  // ----------------------------------------
  // Alarm indication signal
  // ----------------------------------------
  logic [12:0] aisBits_r;
  logic [12:0] aisZeros_r;
  logic [12:0] aisTotal;
  logic aisOk;
  logic aisPrevOk_r;
  logic aisOn_r;
  logic aisCause;
  assign aisTotal = aisZeros_r + {12'h000, ~dataSync_r};
  assign aisOk = isT1 ? (aisTotal <= AIS_MAX_ZERO_T1)
    : (aisTotal <= AIS_MAX_ZERO_E1);
  assign aisCause = isT1 ? cur.frameLoss : basicFrameAlignLoss;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aisBits_r <= 13'h0000;
      aisZeros_r <= 13'h0000;
      aisPrevOk_r <= 1'b0;
      aisOn_r <= 1'b0;
    end
    else
    begin
      if (bitStb)
      begin
        // A rate change can leave the count past the shorter window
        if (aisBits_r >= (isT1 ? AIS_WIN_T1 : AIS_WIN_E1) - 13'h0001)
        begin
          aisBits_r <= 13'h0000;
          aisZeros_r <= 13'h0000;
          aisPrevOk_r <= aisOk;
          if (isT1)
            aisOn_r <= aisOk & cur.frameLoss;
          else
            aisOn_r <= aisOk & aisPrevOk_r & basicFrameAlignLoss;
        end
        else
        begin
          aisBits_r <= aisBits_r + 13'h0001;
          aisZeros_r <= aisTotal;
        end
      end
      if (!aisCause)
        aisOn_r <= 1'b0;
    end
  end

  alarm_s live;
  always_comb
  begin
    live = cur;
    live.rxAlarmInd = aisOn_r;
  end

  // ----------------------------------------
  // Interrupt status and one-second hold
  // ----------------------------------------
  logic [4:0] liveLast_r;
  logic [4:0] rise;
  logic [4:0] alarm1Int_r;
  logic [4:0] accInt_r;
  logic [4:0] accSt_r;
  logic [4:0] heldSt_r;
  logic intRead;
  assign rise = live & ~liveLast_r;
  assign intRead = regRd && (regAddr == OFS_ALARM1_INT_STATUS);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      liveLast_r <= 5'h00;
      alarm1Int_r <= 5'h00;
      accInt_r <= 5'h00;
      accSt_r <= 5'h00;
      heldSt_r <= 5'h00;
    end
    else
    begin
      liveLast_r <= live;
      if (holdOn)
      begin
        // Captures taken at the tick include same-cycle events
        accInt_r <= oneSecondTick ? rise : (accInt_r | rise);
        accSt_r <= oneSecondTick ? live : (accSt_r | live);
        if (oneSecondTick)
        begin
          alarm1Int_r <= accInt_r | rise;
          heldSt_r <= accSt_r | live;
        end
      end
      else
      begin
        accInt_r <= 5'h00;
        accSt_r <= 5'h00;
        // Set wins over the clearing read
        alarm1Int_r <= (intRead ? 5'h00 : alarm1Int_r) | rise;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      alarmIrq <= 1'b0;
    else
      alarmIrq <= |(alarm1Int_r & alarm1Ena_r);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      regRdData <= 8'h00;
    else if (regRd)
    begin
      case (regAddr)
        OFS_PRIMARY_CONTROL: regRdData <= primaryCtrl_r;
        OFS_ALARM1_INT_STATUS: regRdData <= {3'b000, alarm1Int_r};
        OFS_ALARM2_INT_STATUS: regRdData <= {7'h00, cntOvf_r};
        OFS_ALARM1_INT_ENABLE: regRdData <= {3'b000, alarm1Ena_r};
        OFS_RECEIVER_CONFIGURATION: regRdData <= rxConfig_r;
        OFS_RX_ALARM_SIGNAL_CONFIG: regRdData <= signalCfg_r;
        OFS_ALARM_ERROR_LATCH_CONFIG: regRdData <= latchCfg_r;
        OFS_ALARM1_STATUS:
          regRdData <= {3'b000, holdOn ? heldSt_r : live};
        OFS_ALARM3_STATUS:
          regRdData <= {2'b00, reason_r, 1'b0, signalingMultiframeAlignLoss,
            crcMultiframeAlignLoss, basicFrameAlignLoss};
        OFS_ALARM_EVENT_COUNTER: regRdData <= {4'h0, lossCnt_r};
        OFS_TX_ALARM_CONFIG: regRdData <= txCfg_r;
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_IRQ_GATED: assert property (
    $rose(alarmIrq) |-> $past(|(alarm1Int_r & alarm1Ena_r)))
    else $error("interrupt without enabled status");
  AST_READ_CLEARS: assert property (
    intRead && !holdOn && rise == 5'h00 |=> alarm1Int_r == 5'h00)
    else $error("status not cleared by read");
  AST_HOLD_STEADY: assert property (
    holdOn && !oneSecondTick |=> $stable(heldSt_r))
    else $error("held status changed mid interval");
  AST_E1_OR: assert property (
    !isT1 |-> cur.frameLoss == (basicFrameAlignLoss
      | crcMultiframeAlignLoss | signalingMultiframeAlignLoss))
    else $error("E1 frame loss not OR of losses");
  AST_T1_BASIC_FRAME_ALIGN_LOSS: assert property (
    isT1 && !integOn |-> cur.frameLoss == basicFrameAlignLoss)
    else $error("T1 frame loss differs from alignment loss");
  AST_LOS_SET: assert property (
    losState_r == LOS_IDLE && losRun |=> sigLoss_r)
    else $error("signal loss not declared");
  AST_CLOCK_LOSS: assert property (
    signalCfg_r[BIT_ANALOG_SOURCE] && clockAbsent |-> cur.analogLoss)
    else $error("clock loss not reported");
  AST_COUNT: assert property (
    fredRise && !cntRead |=> lossCnt_r == $past(lossCnt_r) + 4'h1)
    else $error("alignment loss not counted");
  AST_AUTO_TX: assert property (
    txCfg_r[BIT_AUTO_TX_ALARM] && sigLoss_r |=> txAlarmRequest)
    else $error("no transmit alarm on signal loss");

endmodule

`default_nettype wire

// ### bench/liu_model.sv
/*
  Behavioural line interface unit: recovered line clock and data.
  Assumes the bench steers it with plain levels; the clock runs free
  while clkRun is high.
*/
`timescale 1ns/1ps
`default_nettype none

module liu_model
(
  // Control from bench
  input wire logic clkRun,
  input wire logic sendOnes,
  // Line side
  output logic lineClk,
  output logic lineData
);
  initial
  begin
    lineClk = 1'b0;
    lineData = 1'b1;
  end

  // ----------------------------------------
  // Clock and data, 320 ns bit period
  // ----------------------------------------
  always
  begin
    #160;
    if (clkRun)
    begin
      lineClk = ~lineClk;
      if (!lineClk)
      begin
        lineData = sendOnes;
      end
    end
    else
    begin
      // Released line: data wanders so no stale value looks valid
      lineClk = 1'b0;
      lineData = ~lineData;
    end
  end
endmodule

`default_nettype wire

// ### bench/tb.sv
/*
  Self-checking bench of the receive alarm monitor.
  Assumes the monitor's package and a line model that starts running.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rx_alarm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData, frameCriteria, rdVal;
  logic lineClk, lineData, txAlarmRequest, alarmIrq;
  logic clkRun = 1'b1;
  logic sendOnes = 1'b1;
  logic basicLoss = 1'b0;
  logic crcLoss = 1'b0;
  logic sigLoss = 1'b0;
  logic [1:0] lossReason = 2'b00;
  logic remote = 1'b0;
  logic tick = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  liu_model line (.clkRun(clkRun), .sendOnes(sendOnes), .lineClk(lineClk),
    .lineData(lineData));

  // Short counts keep the run brief
  rx_line_alarm_monitor #(.INTEG_LEN(200), .ANALOG_LEN(50)) uut (.clk(clk),
    .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .rxLineClockIn(lineClk),
    .rxLineData(lineData), .basicFrameAlignLoss(basicLoss),
    .crcMultiframeAlignLoss(crcLoss), .signalingMultiframeAlignLoss(sigLoss),
    .frameLossReason(lossReason), .remoteAlarmIndication(remote),
    .oneSecondTick(tick), .frameCriteria(frameCriteria),
    .txAlarmRequest(txAlarmRequest), .alarmIrq(alarmIrq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bits(input int n);
    repeat (n) @(posedge lineClk);
    cyc(6);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    // Read data stand until this edge updates them
    @(posedge clk);
    rdVal = regRdData;
  endtask

  task automatic pulse_tick();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic regs_case();
    logic [7:0] rw [6] = '{OFS_PRIMARY_CONTROL, OFS_ALARM1_INT_ENABLE,
      OFS_RECEIVER_CONFIGURATION, OFS_RX_ALARM_SIGNAL_CONFIG,
      OFS_ALARM_ERROR_LATCH_CONFIG, OFS_TX_ALARM_CONFIG};
    foreach (rw[i])
    begin
      rd(rw[i]);
      chk8(rdVal, REG_RESET);
      wr(rw[i], 8'hA5);
      rd(rw[i]);
      chk8(rdVal, (rw[i] == OFS_ALARM1_INT_ENABLE) ? 8'h05 : 8'hA5);
      wr(rw[i], 8'h00);
    end
    wr(OFS_RECEIVER_CONFIGURATION, 8'h3C);
    cyc(2);
    chk8(frameCriteria, 8'h3C);
    rd(8'h02);
    chk8(rdVal, 8'h00);
  endtask

  task automatic los_case(input logic [7:0] rate, input int n);
    wr(OFS_PRIMARY_CONTROL, rate);
    wr(OFS_TX_ALARM_CONFIG, 8'h01);
    sendOnes <= 1'b1;
    bits(250);
    @(negedge lineClk);
    @(posedge clk);
    sendOnes <= 1'b0;
    @(posedge lineClk);
    bits(n - 1);
    chk1(txAlarmRequest, 1'b0);
    bits(1);
    chk1(txAlarmRequest, 1'b1);
    cyc(60);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h06);
    sendOnes <= 1'b1;
    bits(200);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h06);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h00);
    wr(OFS_TX_ALARM_CONFIG, 8'h00);
  endtask

  task automatic clock_loss_case();
    wr(OFS_RX_ALARM_SIGNAL_CONFIG, 8'h02);
    clkRun <= 1'b0;
    cyc(150);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h04);
    clkRun <= 1'b1;
    cyc(60);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h04);
    wr(OFS_RX_ALARM_SIGNAL_CONFIG, 8'h00);
  endtask

  task automatic frame_e1_case();
    wr(OFS_PRIMARY_CONTROL, 8'h00);
    lossReason <= 2'b10;
    crcLoss <= 1'b1;
    cyc(4);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h01);
    rd(OFS_ALARM3_STATUS);
    chk8(rdVal, 8'h22);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h01);
    crcLoss <= 1'b0;
    sigLoss <= 1'b1;
    cyc(4);
    rd(OFS_ALARM3_STATUS);
    chk8(rdVal, 8'h24);
    sigLoss <= 1'b0;
    rd(OFS_ALARM1_INT_STATUS);
  endtask

  task automatic frame_t1_case();
    wr(OFS_PRIMARY_CONTROL, 8'h01);
    rd(OFS_ALARM_EVENT_COUNTER);
    crcLoss <= 1'b1;
    cyc(4);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    basicLoss <= 1'b1;
    cyc(4);
    chk1(alarmIrq, 1'b0);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h01);
    wr(OFS_ALARM1_INT_ENABLE, 8'h01);
    cyc(3);
    chk1(alarmIrq, 1'b1);
    rd(OFS_ALARM1_INT_STATUS);
    cyc(3);
    chk1(alarmIrq, 1'b0);
    rd(OFS_ALARM_EVENT_COUNTER);
    chk8(rdVal, 8'h01);
    basicLoss <= 1'b0;
    crcLoss <= 1'b0;
    wr(OFS_ALARM1_INT_ENABLE, 8'h00);
    repeat (16)
    begin
      cyc(2);
      basicLoss <= 1'b1;
      cyc(2);
      basicLoss <= 1'b0;
    end
    rd(OFS_ALARM_EVENT_COUNTER);
    chk8(rdVal, 8'h00);
    rd(OFS_ALARM2_INT_STATUS);
    chk8(rdVal, 8'h01);
  endtask

  task automatic integ_case();
    wr(OFS_RX_ALARM_SIGNAL_CONFIG, 8'h01);
    cyc(250);
    rd(OFS_ALARM1_INT_STATUS);
    basicLoss <= 1'b1;
    cyc(150);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    rd(OFS_ALARM_EVENT_COUNTER);
    chk8(rdVal, 8'h01);
    cyc(100);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h01);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h01);
    basicLoss <= 1'b0;
    cyc(250);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    wr(OFS_RX_ALARM_SIGNAL_CONFIG, 8'h00);
  endtask

  task automatic hold_case();
    wr(OFS_ALARM_ERROR_LATCH_CONFIG, 8'h01);
    pulse_tick();
    remote <= 1'b1;
    cyc(3);
    remote <= 1'b0;
    cyc(3);
    pulse_tick();
    cyc(3);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h10);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h10);
    rd(OFS_ALARM1_INT_STATUS);
    chk8(rdVal, 8'h10);
    wr(OFS_ALARM_ERROR_LATCH_CONFIG, 8'h00);
  endtask

  task automatic ais_case();
    wr(OFS_PRIMARY_CONTROL, 8'h00);
    basicLoss <= 1'b1;
    bits(1600);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h09);
    basicLoss <= 1'b0;
    cyc(4);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
    // E1 windows leave the count low, so one whole T1 window of ones follows
    wr(OFS_PRIMARY_CONTROL, 8'h01);
    basicLoss <= 1'b1;
    bits(4650);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h09);
    basicLoss <= 1'b0;
    cyc(4);
    rd(OFS_ALARM1_STATUS);
    chk8(rdVal, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    regs_case();
    los_case(8'h00, 32);
    los_case(8'h01, 100);
    clock_loss_case();
    frame_e1_case();
    frame_t1_case();
    integ_case();
    hold_case();
    ais_case();
    close_out();
  end
endmodule

`default_nettype wire
